/* cfg_lock_event.sv */
// Configuration lock for one port, its two config registers, and event routing.
// Assumes a classic Wishbone master on clk_i and a synchronous reset.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - The lock key bit reads back 0 while unlocked and 1 once the lock is active.
// - Any deviation in order or value in the key sequence prevents locking.
// - With the lock active, writes to locked pins' configuration fields are ignored until reset.
// - Mask bits 0 to 7 guard the pin fields of the low configuration register, bits 8 to 15 those of the high one.
// - The mask may change only while the lock is not active.
// - With event output enabled, the core event signal drives the selected port pin.
// - Port select codes 0 to 3 choose ports A to D, other codes are reserved.
// - Pin select picks pin 0 to 15 of the chosen port.
// - Event control, remap and four interrupt select registers reset to zero.
module cfg_lock_event
  import cfg_lock_event_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Core event
  input  wire logic        core_event_signal_i,
  // Event routing, one bit per port pin
  output logic [15:0]      event_pin_a_o,
  output logic [15:0]      event_pin_b_o,
  output logic [15:0]      event_pin_c_o,
  output logic [15:0]      event_pin_d_o,
  // Configuration state
  output logic [31:0]      pin_config_low_half_o,
  output logic [31:0]      pin_config_high_half_o,
  output logic [31:0]      peripheral_remap_o,
  output logic             lock_active_o
);

  typedef enum logic [3:0] {
    KEY_IDLE  = 4'b0001,
    KEY_ONE   = 4'b0010,
    KEY_ZERO  = 4'b0100,
    KEY_ARMED = 4'b1000
  } key_state_t;

  key_state_t  key_q;
  logic        lock_q;
  logic [15:0] mask_q;
  logic [7:0]  ev_ctrl_q;
  logic [31:0] remap_q;
  logic [31:0] irq_sel_q [4];
  logic [31:0] cfg_low_q;
  logic [31:0] cfg_high_q;
  logic [31:0] cfg_wmask_low;
  logic [31:0] cfg_wmask_high;

  logic        req;
  logic        wr_full;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] rdata_d;

  // Single-cycle answer; ack drops after one cycle
  assign req     = cyc_i && stb_i && !ack_o && !err_o;
  // Partial word writes are dropped; the block only serves words
  assign wr_full = sel_i == 4'hf;
  assign wr      = req && we_i && hit && wr_full;
  assign rd      = req && !we_i && hit;

  always_comb begin
    hit     = 1'b1;
    rdata_d = RESET_ZERO;
    case (adr_i)
      ADDR_EVENT_CTRL: rdata_d = {24'h000000, ev_ctrl_q};
      ADDR_REMAP:      rdata_d = remap_q;
      ADDR_IRQ_SEL_1:  rdata_d = irq_sel_q[0];
      ADDR_IRQ_SEL_2:  rdata_d = irq_sel_q[1];
      ADDR_IRQ_SEL_3:  rdata_d = irq_sel_q[2];
      ADDR_IRQ_SEL_4:  rdata_d = irq_sel_q[3];
      ADDR_LOCK:       rdata_d = {15'h0, lock_q, mask_q};
      ADDR_CFG_LOW:    rdata_d = cfg_low_q;
      ADDR_CFG_HIGH:   rdata_d = cfg_high_q;
      default:         hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= RESET_ZERO;
    end else begin
      ack_o <= req && hit;
      err_o <= req && !hit;
      // Zero outside the ack cycle keeps the bus quiet
      dat_o <= (req && !we_i && hit) ? rdata_d : RESET_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_q <= KEY_IDLE;
    end else if (req && hit && adr_i == ADDR_LOCK && !lock_q) begin
      case (key_q)
        KEY_IDLE: begin
          if (wr && dat_i[LOCK_KEY_BIT]) begin
            key_q <= KEY_ONE;
          end
        end
        KEY_ONE: begin
          // wrong value or changed mask aborts
          if (wr && !dat_i[LOCK_KEY_BIT] && dat_i[15:0] == mask_q) begin
            key_q <= KEY_ZERO;
          end else begin
            key_q <= KEY_IDLE;
          end
        end
        KEY_ZERO: begin
          if (wr && dat_i[LOCK_KEY_BIT] && dat_i[15:0] == mask_q) begin
            key_q <= KEY_ARMED;
          end else begin
            key_q <= KEY_IDLE;
          end
        end
        KEY_ARMED: key_q <= KEY_IDLE;
        default:   key_q <= KEY_IDLE;
      endcase
    end else if (req && hit && !lock_q && key_q != KEY_IDLE) begin
      key_q <= KEY_IDLE;
    end
  end

  // lock set by armed read, cleared only by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (rd && adr_i == ADDR_LOCK && key_q == KEY_ARMED) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= 16'h0000;
    end else if (wr && adr_i == ADDR_LOCK && !lock_q) begin
      mask_q <= dat_i[15:0];
    end
  end

  // mask bits 0-7 each cover a 4-bit field of the low half, bits 8-15 of the high half
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT / 2; g++) begin : g_wmask
      assign cfg_wmask_low[g*CFG_FIELD_W +: CFG_FIELD_W]  = {CFG_FIELD_W{!(lock_q && mask_q[g])}};
      assign cfg_wmask_high[g*CFG_FIELD_W +: CFG_FIELD_W] = {CFG_FIELD_W{!(lock_q && mask_q[g+8])}};
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_low_q  <= RESET_CFG;
      cfg_high_q <= RESET_CFG;
    end else if (wr) begin
      if (adr_i == ADDR_CFG_LOW) begin
        cfg_low_q <= (dat_i & cfg_wmask_low) | (cfg_low_q & ~cfg_wmask_low);
      end
      if (adr_i == ADDR_CFG_HIGH) begin
        cfg_high_q <= (dat_i & cfg_wmask_high) | (cfg_high_q & ~cfg_wmask_high);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_ctrl_q <= 8'h00;
      remap_q   <= RESET_ZERO;
      for (int i = 0; i < 4; i++) begin
        irq_sel_q[i] <= RESET_ZERO;
      end
    end else if (wr) begin
      case (adr_i)
        ADDR_EVENT_CTRL: ev_ctrl_q    <= dat_i[7:0] & EV_CTRL_MASK;
        ADDR_REMAP:      remap_q      <= dat_i & REMAP_MASK;
        ADDR_IRQ_SEL_1:  irq_sel_q[0] <= dat_i & IRQ_SEL_MASK;
        ADDR_IRQ_SEL_2:  irq_sel_q[1] <= dat_i & IRQ_SEL_MASK;
        ADDR_IRQ_SEL_3:  irq_sel_q[2] <= dat_i & IRQ_SEL_MASK;
        ADDR_IRQ_SEL_4:  irq_sel_q[3] <= dat_i & IRQ_SEL_MASK;
        default: ;
      endcase
    end
  end

  logic [15:0] ev_pins_d [PORT_COUNT];
  logic [15:0] ev_pins_q [PORT_COUNT];
  logic        ev_en;
  logic [2:0]  ev_port;
  logic [3:0]  ev_pin;
  assign ev_en   = ev_ctrl_q[EV_ENABLE_BIT];
  assign ev_port = ev_ctrl_q[EV_PORT_LSB +: 3];
  assign ev_pin  = ev_ctrl_q[EV_PIN_LSB +: 4];

  generate
    for (g = 0; g < PORT_COUNT; g++) begin : g_port
      assign ev_pins_d[g] = (ev_en && ev_port == 3'(g))
                            ? (16'(core_event_signal_i) << ev_pin) : 16'h0000;
      // Registered so pins never glitch on control writes
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ev_pins_q[g] <= 16'h0000;
        end else begin
          ev_pins_q[g] <= ev_pins_d[g];
        end
      end
    end
  endgenerate

  assign event_pin_a_o          = ev_pins_q[0];
  assign event_pin_b_o          = ev_pins_q[1];
  assign event_pin_c_o          = ev_pins_q[2];
  assign event_pin_d_o          = ev_pins_q[3];
  assign pin_config_low_half_o  = cfg_low_q;
  assign pin_config_high_half_o = cfg_high_q;
  assign peripheral_remap_o     = remap_q;
  assign lock_active_o          = lock_q;

  // Assertions
  // lock stays set for 8 cycles after it rises
  a_lock_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(lock_q) |=> lock_q [*8])
    else $error("lock dropped without reset");

  a_lock_needs_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(lock_q) |-> $past(key_q) == KEY_ARMED)
    else $error("lock set outside sequence");

  a_key_value_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (!lock_q && key_q == KEY_ZERO && wr && adr_i == ADDR_LOCK && !dat_i[LOCK_KEY_BIT]) |=> key_q == KEY_IDLE)
    else $error("bad key value kept the sequence");

  a_key_mask_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (!lock_q && key_q == KEY_ZERO && wr && adr_i == ADDR_LOCK && dat_i[15:0] != mask_q) |=> key_q == KEY_IDLE)
    else $error("changed mask kept the sequence");

  a_key_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == ADDR_LOCK) |=> dat_o[LOCK_KEY_BIT] == $past(lock_q))
    else $error("key bit readback wrong");

  a_arm_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(lock_q) |-> !dat_o[LOCK_KEY_BIT])
    else $error("arming read returned key set");

  a_mask_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_q |=> $stable(mask_q))
    else $error("mask changed while locked");

  a_cfg_guarded: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_q && mask_q[0]) |=> cfg_low_q[3:0] == $past(cfg_low_q[3:0]))
    else $error("locked low field changed");

  a_cfg_high_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_q && mask_q[8]) |=> cfg_high_q[3:0] == $past(cfg_high_q[3:0]))
    else $error("locked high field changed");

  a_cfg_low_open: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == ADDR_CFG_LOW && !(lock_q && mask_q[1])) |=> cfg_low_q[7:4] == $past(dat_i[7:4]))
    else $error("open low field not written");

  a_cfg_high_open: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == ADDR_CFG_HIGH && !(lock_q && mask_q[9])) |=> cfg_high_q[7:4] == $past(dat_i[7:4]))
    else $error("open high field not written");

  a_partial_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && sel_i != 4'hf && adr_i == ADDR_EVENT_CTRL) |=> $stable(ev_ctrl_q))
    else $error("partial write landed");

  a_event_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_en && ev_port == 3'h1 && core_event_signal_i) |=> event_pin_b_o[$past(ev_pin)])
    else $error("event not routed");

  a_event_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !core_event_signal_i |=> (event_pin_a_o | event_pin_b_o | event_pin_c_o | event_pin_d_o) == 16'h0)
    else $error("pin driven without core event");

  a_event_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_port > EV_PORT_LAST || !ev_en) |=> (event_pin_a_o | event_pin_b_o | event_pin_c_o | event_pin_d_o) == 16'h0)
    else $error("event on reserved port");

  a_one_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(event_pin_a_o))
    else $error("more than one pin driven");

  a_reset_zero: assert property (@(posedge clk_i)
    rst_i |=> ev_ctrl_q == 8'h00 && remap_q == RESET_ZERO)
    else $error("registers not zero after reset");

  a_reset_irq: assert property (@(posedge clk_i)
    rst_i |=> irq_sel_q[0] == RESET_ZERO && irq_sel_q[3] == RESET_ZERO)
    else $error("interrupt selects not zero after reset");

  // Main scenarios
  c_lock_taken:    cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_q));
  c_seq_abort:     cover property (@(posedge clk_i) disable iff (rst_i) key_q == KEY_ZERO ##1 key_q == KEY_IDLE);
  c_event_out:     cover property (@(posedge clk_i) disable iff (rst_i) event_pin_d_o != 16'h0);
  c_key_armed:     cover property (@(posedge clk_i) disable iff (rst_i) key_q == KEY_ARMED);
  c_partial_write: cover property (@(posedge clk_i) disable iff (rst_i) req && we_i && sel_i != 4'hf);

endmodule

`default_nettype wire

/* cfg_lock_event_pkg.sv */
// Constants for the pin configuration lock and event routing block.
// Assumes a 32-bit classic Wishbone slave on a single clock.
package cfg_lock_event_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_EVENT_CTRL   = 32'h4001_0000;
  localparam logic [31:0] ADDR_REMAP        = 32'h4001_0004;
  localparam logic [31:0] ADDR_IRQ_SEL_1    = 32'h4001_0008;
  localparam logic [31:0] ADDR_IRQ_SEL_2    = 32'h4001_000c;
  localparam logic [31:0] ADDR_IRQ_SEL_3    = 32'h4001_0010;
  localparam logic [31:0] ADDR_IRQ_SEL_4    = 32'h4001_0014;
  localparam logic [31:0] ADDR_LOCK         = 32'h4001_0018;
  localparam logic [31:0] ADDR_CFG_LOW      = 32'h4001_001c;
  localparam logic [31:0] ADDR_CFG_HIGH     = 32'h4001_0020;

  // Reset values
  localparam logic [31:0] RESET_ZERO        = 32'h0000_0000;
  localparam logic [31:0] RESET_CFG         = 32'h4444_4444;

  // Event control fields
  localparam int          EV_ENABLE_BIT     = 7;
  localparam int          EV_PORT_LSB       = 4;
  localparam int          EV_PIN_LSB        = 0;
  localparam logic [7:0]  EV_CTRL_MASK      = 8'hff;
  localparam logic [2:0]  EV_PORT_LAST      = 3'h3;

  // Lock register fields
  localparam int          LOCK_KEY_BIT      = 16;
  localparam int          PIN_COUNT         = 16;
  localparam int          PORT_COUNT        = 4;
  localparam int          CFG_FIELD_W       = 4;

  // Remap and interrupt select writable bits
  localparam logic [31:0] REMAP_MASK        = 32'h07ff_efff;
  localparam logic [31:0] IRQ_SEL_MASK      = 32'h0000_ffff;

endpackage

/* gpio_config_lock_event_route_tb.sv */
// Testbench for the configuration lock and event routing block.
// Assumes cfg_lock_event answers every Wishbone request within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module gpio_config_lock_event_route_tb import cfg_lock_event_pkg::*;;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [31:0] adr_i = 32'h0000_0000;
  logic [3:0]  sel_i = 4'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic        core_event_signal_i = 1'b1;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic [15:0] ev [4];
  logic [31:0] pin_config_low_half_o;
  logic [31:0] pin_config_high_half_o;
  logic [31:0] peripheral_remap_o;
  logic        lock_active_o;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  pt;
  logic [3:0]  pn;
  int          n_errors = 0;
  int          checks_done = 0;

  cfg_lock_event uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .core_event_signal_i(core_event_signal_i), .event_pin_a_o(ev[0]), .event_pin_b_o(ev[1]),
    .event_pin_c_o(ev[2]), .event_pin_d_o(ev[3]), .pin_config_low_half_o(pin_config_low_half_o),
    .pin_config_high_half_o(pin_config_high_half_o), .peripheral_remap_o(peripheral_remap_o),
    .lock_active_o(lock_active_o));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Held until ack or err is sampled, then released for a cycle
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    // word access unless a test drops bytes
    sel_i <= be;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("mismatch bus answer expected ack seen none");
    end
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, rd, er);
  endtask

  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000, rd, er);
    chk(nm, rd, exp);
  endtask

  // Three key writes, mask given per write
  task automatic key_seq(input logic [15:0] m1, input logic [15:0] m2, input logic [15:0] m3,
                         input logic [2:0] k);
    wr(ADDR_LOCK, {15'h0, k[2], m1});
    wr(ADDR_LOCK, {15'h0, k[1], m2});
    wr(ADDR_LOCK, {15'h0, k[0], m3});
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rc("reset zero", ADDR_EVENT_CTRL + 32'(4 * i), RESET_ZERO);
    end
    rc("lock reset", ADDR_LOCK, RESET_ZERO);
    rc("cfg low reset", ADDR_CFG_LOW, RESET_CFG);
    rc("cfg high reset", ADDR_CFG_HIGH, RESET_CFG);
    chk("event idle", {ev[0], ev[1]}, 32'h0000_0000);
    xfer(32'h4001_0100, 1'b0, 32'h0000_0000, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h0000_0001);
    wr(ADDR_REMAP, 32'hffff_ffff);
    rc("remap mask", ADDR_REMAP, REMAP_MASK);
    chk("remap port", peripheral_remap_o, REMAP_MASK);
    wr(ADDR_IRQ_SEL_2, 32'hffff_ffff);
    rc("irq select mask", ADDR_IRQ_SEL_2, IRQ_SEL_MASK);
    // Last pass keeps a valid port but clears the enable
    for (int p = 0; p < 6; p++) begin
      pt = (p == 5) ? 3'h1 : 3'(p);
      pn = 4'(p * 4 + 3);
      wr(ADDR_EVENT_CTRL, {24'h0, (p < 5), pt, pn});
      repeat (2) @(posedge clk_i);
      for (int q = 0; q < 4; q++) begin
        chk("event pin", {16'h0, ev[q]}, (p < 5 && pt == 3'(q)) ? 32'h1 << pn : 32'h0);
      end
    end
    wr(ADDR_EVENT_CTRL, 32'h0000_00a5);
    core_event_signal_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("event core low", {16'h0, ev[2]}, 32'h0000_0000);
    core_event_signal_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("event core high", {16'h0, ev[2]}, 32'h0000_0020);
    be = 4'h3;
    wr(ADDR_EVENT_CTRL, 32'h0000_0000);
    be = 4'hf;
    rc("partial write dropped", ADDR_EVENT_CTRL, 32'h0000_00a5);
    key_seq(16'h0101, 16'h0101, 16'h0101, 3'b100);
    rc("bad order", ADDR_LOCK, 32'h0000_0101);
    key_seq(16'h0101, 16'h0101, 16'h0303, 3'b101);
    rc("mask changed", ADDR_LOCK, 32'h0000_0303);
    rc("still open", ADDR_LOCK, 32'h0000_0303);
    key_seq(16'h0101, 16'h0101, 16'h0101, 3'b101);
    rc("key first read", ADDR_LOCK, 32'h0000_0101);
    rc("key second read", ADDR_LOCK, 32'h0001_0101);
    chk("lock state", {31'h0, lock_active_o}, 32'h0000_0001);
    wr(ADDR_LOCK, 32'h0000_ffff);
    rc("mask frozen", ADDR_LOCK, 32'h0001_0101);
    wr(ADDR_CFG_LOW, 32'h1111_1111);
    wr(ADDR_CFG_HIGH, 32'h1111_1111);
    rc("cfg low locked", ADDR_CFG_LOW, 32'h1111_1114);
    rc("cfg high locked", ADDR_CFG_HIGH, 32'h1111_1114);
    chk("cfg low port", pin_config_low_half_o, 32'h1111_1114);
    chk("cfg high port", pin_config_high_half_o, 32'h1111_1114);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("lock cleared", ADDR_LOCK, RESET_ZERO);
    chk("lock state off", {31'h0, lock_active_o}, 32'h0000_0000);
    chk("remap after reset", peripheral_remap_o, RESET_ZERO);
    chk("cfg low after reset", pin_config_low_half_o, RESET_CFG);
    give_verdict();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
